//--- lcrb_channel.sv
// Register bank, counters, pulse meters and coil orders of one channel
//
// Contract
// RULE1: Channel N sits 40 times (N-1) above.
// RULE2: Breaker status bit 0 shows closed.
// RULE3: Breaker status bit 1 shows not tripped.
// RULE4: Cycle and trip counters, 32-bit, writable.
// RULE5: Writable 32-bit running time in hours.
// RULE6: Two independent pulse meters per channel.
// RULE7: Status bits 0/1 mirror both pulse outputs.
// RULE8: Flow float equals 3600*weight per interval.
// RULE9: Consumption equals pulse count times weight.
// RULE10: Writable 16-bit weight per meter, default 10.
// RULE11: Contactor status bit 0 shows closed.
// RULE12: Contactor status bit 1 shows device present.
// RULE13: Order bit 0 opens, bit 1 closes coil.
// RULE14: Acted order clears; stays without product.
// RULE15: Both order bits set means no action.
// RULE16: Client sends one order, waits clearing.
// RULE17: 32-bit values: high word at lower address.
`timescale 1ns/1ns
module lcrb_channel #(
	parameter int CH_INDEX = 1,
	parameter logic [39:0] CYC_PER_HOUR = lcrb_pkg::HOUR_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] product_kind,
	input wire logic first_pulse_input,
	input wire logic second_pulse_input,
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_ack,
	output logic reg_err,
	output logic coil_drive_input
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (CH_INDEX < 1 || CH_INDEX > lcrb_pkg::CH_MAX) begin : g_bad_ch
		$error("Channel index out of range");
	end
	if (CYC_PER_HOUR == 40'h00_0000_0000) begin : g_bad_hour
		$error("Cycles per hour must not be zero");
	end

	localparam logic [15:0] CH_OFS = 16'(lcrb_pkg::CH_SPAN * (CH_INDEX - 1));

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sync1;
		logic [1:0] sync2;
		logic [1:0] sync3;
		logic [1:0] lvl;
		logic [1:0] order;
		logic coil;
		logic [31:0] cycles;
		logic [31:0] trips;
		logic [31:0] hours;
		logic [39:0] hour_acc;
		logic [1:0][15:0] weight;
		logic [1:0][31:0] count;
		logic [1:0][39:0] timer;
		logic [1:0] have_prev;
		logic [1:0] pend;
		logic [1:0][39:0] period;
		logic [1:0][31:0] flow;
		logic div_busy;
		logic div_m;
		logic [6:0] div_cnt;
		logic [40:0] div_rem;
		logic [71:0] div_q;
		logic [39:0] div_d;
		logic [15:0] rdata;
		logic ack;
		logic err;
	} lcrb_state_t;

	lcrb_state_t state_reg;
	lcrb_state_t state_next;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Fixed point quotient with FRAC fraction bits to IEEE single, truncated
	function automatic logic [31:0] lcrb_to_float(input logic [71:0] q);
		logic [31:0] f;
		logic [71:0] n;
		int p;
		f = 32'h0000_0000;
		n = q;
		p = -1;
		for (int i = 0; i < lcrb_pkg::QUOT_W; i++) begin
			if (q[i]) begin
				p = i;
			end
		end
		if (p >= 0) begin
			n = q << (71 - p);
			f = {1'b0, 8'(int'(lcrb_pkg::FLT_BIAS) + p - lcrb_pkg::FRAC), n[70:48]};
		end
		return f;
	endfunction

	// High word at the lower address, low word above it
	function automatic logic [15:0] lcrb_half(input logic [31:0] v, input logic low);
		return low ? v[15:0] : v[31:16]; // [RULE17]
	endfunction

	function automatic logic [31:0] lcrb_put(input logic [31:0] v, input logic low,
		input logic [15:0] w);
		return low ? {v[31:16], w} : {w, v[15:0]}; // [RULE17]
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	lcrb_pkg::lcrb_kind_t kind;
	logic [15:0] rel;
	logic [1:0] rise;
	logic [1:0] fall;
	logic closed;
	logic present;
	logic [1:0][31:0] cons;
	logic [40:0] rem_sh;
	logic [71:0] q_sh;
	logic [71:0] dividend;
	logic [15:0] status;

	always_comb begin
		state_next = state_reg;
		kind = lcrb_pkg::lcrb_kind_t'(product_kind);
		rel = reg_addr - CH_OFS; // [RULE1]
		rem_sh = 41'h000_0000_0000;
		q_sh = 72'h00_0000_0000_0000_0000;
		dividend = 72'h00_0000_0000_0000_0000;

		// Pins pass three flops; a level counts once stages two and three agree
		state_next.sync1 = {second_pulse_input, first_pulse_input};
		state_next.sync2 = state_reg.sync1;
		state_next.sync3 = state_reg.sync2;
		for (int i = 0; i < 2; i++) begin
			if (state_reg.sync2[i] == state_reg.sync3[i]) begin
				state_next.lvl[i] = state_reg.sync3[i];
			end
		end
		rise = state_next.lvl & ~state_reg.lvl;
		fall = ~state_next.lvl & state_reg.lvl;

		closed = state_reg.lvl[lcrb_pkg::BIT_FIRST] &&
			(kind == lcrb_pkg::KIND_BREAKER || kind == lcrb_pkg::KIND_CONTACTOR);
		present = (kind == lcrb_pkg::KIND_BREAKER) ||
			(kind == lcrb_pkg::KIND_CONTACTOR && state_reg.lvl[lcrb_pkg::BIT_SECOND]); // [RULE12]

		// Status word; reserved bits read as zero
		status = 16'h0000;
		if (kind != lcrb_pkg::KIND_NONE) begin
			status[1:0] = state_reg.lvl; // [RULE2] [RULE3] [RULE7] [RULE11] [RULE12]
		end

		// Switching, trip and running time counters
		if (kind == lcrb_pkg::KIND_BREAKER || kind == lcrb_pkg::KIND_CONTACTOR) begin
			if (rise[lcrb_pkg::BIT_FIRST]) begin
				state_next.cycles = state_reg.cycles + 32'h0000_0001; // [RULE4]
			end
		end
		if (kind == lcrb_pkg::KIND_BREAKER && fall[lcrb_pkg::BIT_SECOND]) begin
			state_next.trips = state_reg.trips + 32'h0000_0001; // [RULE4]
		end
		if (closed) begin
			if (state_reg.hour_acc >= CYC_PER_HOUR - 40'h00_0000_0001) begin
				state_next.hour_acc = 40'h00_0000_0000;
				state_next.hours = state_reg.hours + 32'h0000_0001; // [RULE5]
			end else begin
				state_next.hour_acc = state_reg.hour_acc + 40'h00_0000_0001;
			end
		end

		// Pulse meters, one per input
		for (int m = 0; m < 2; m++) begin
			cons[m] = 32'(state_reg.count[m] * {16'h0000, state_reg.weight[m]}); // [RULE9]
			if (state_reg.timer[m] != 40'hFF_FFFF_FFFF) begin
				state_next.timer[m] = state_reg.timer[m] + 40'h00_0000_0001;
			end
			if (kind == lcrb_pkg::KIND_METER && rise[m]) begin // [RULE6]
				state_next.count[m] = state_reg.count[m] + 32'h0000_0001;
				state_next.timer[m] = 40'h00_0000_0001;
				state_next.have_prev[m] = 1'b1;
				if (state_reg.have_prev[m]) begin
					state_next.period[m] = state_reg.timer[m];
					state_next.pend[m] = 1'b1;
				end
			end
		end

		// Shared divider: one flow at a time, 72 steps each
		if (state_reg.div_busy) begin
			rem_sh = {state_reg.div_rem[39:0], state_reg.div_q[71]};
			q_sh = {state_reg.div_q[70:0], 1'b0};
			if (rem_sh >= {1'b0, state_reg.div_d}) begin
				rem_sh = rem_sh - {1'b0, state_reg.div_d};
				q_sh[0] = 1'b1;
			end
			state_next.div_rem = rem_sh;
			state_next.div_q = q_sh;
			state_next.div_cnt = state_reg.div_cnt - 7'h01;
			if (state_reg.div_cnt == 7'h01) begin
				state_next.div_busy = 1'b0;
				state_next.flow[state_reg.div_m] = lcrb_to_float(q_sh); // [RULE8]
			end
		end else if (state_reg.pend != 2'b00) begin
			state_next.div_m = ~state_reg.pend[0];
			state_next.pend[state_next.div_m] = 1'b0;
			// Dividend is weight times cycles per hour, in fixed point
			dividend = (72'(state_reg.weight[state_next.div_m]) * 72'(CYC_PER_HOUR))
				<< lcrb_pkg::FRAC; // [RULE8]
			state_next.div_q = dividend;
			state_next.div_rem = 41'h000_0000_0000;
			state_next.div_d = state_next.period[state_next.div_m]; // Newest period is never lost
			state_next.div_cnt = lcrb_pkg::DIV_STEPS;
			state_next.div_busy = 1'b1;
		end

		// Coil orders: act only on a single bit with a product present
		if (present) begin
			case (state_reg.order)
				2'b01: begin
					state_next.coil = 1'b0; // [RULE13]
					state_next.order = 2'b00; // [RULE14]
				end
				2'b10: begin
					state_next.coil = 1'b1; // [RULE13]
					state_next.order = 2'b00; // [RULE14]
				end
				2'b11: begin
					state_next.order = state_reg.order; // [RULE15]
				end
				default: begin
					state_next.order = state_reg.order;
				end
			endcase
		end

		// Register access; a write overrides any update in the same cycle
		state_next.ack = reg_rd | reg_wr;
		state_next.err = 1'b0;
		state_next.rdata = 16'h0000;
		case (rel)
			lcrb_pkg::A_STATUS: begin
				state_next.rdata = status;
				state_next.err = reg_wr;
			end
			lcrb_pkg::A_ORDER: begin
				state_next.rdata = {14'h0000, state_reg.order};
				if (reg_wr) begin
					state_next.order = reg_wdata[1:0]; // [RULE13] [RULE16]
				end
			end
			lcrb_pkg::A_FLOW1, lcrb_pkg::A_FLOW1 + lcrb_pkg::A_LOW_WORD: begin
				state_next.rdata = lcrb_half(state_reg.flow[0], rel[0]);
				state_next.err = reg_wr;
			end
			lcrb_pkg::A_FLOW2, lcrb_pkg::A_FLOW2 + lcrb_pkg::A_LOW_WORD: begin
				state_next.rdata = lcrb_half(state_reg.flow[1], rel[0]);
				state_next.err = reg_wr;
			end
			lcrb_pkg::A_CONS1, lcrb_pkg::A_CONS1 + lcrb_pkg::A_LOW_WORD: begin
				state_next.rdata = lcrb_half(cons[0], rel[0]);
				state_next.err = reg_wr;
			end
			lcrb_pkg::A_CONS2, lcrb_pkg::A_CONS2 + lcrb_pkg::A_LOW_WORD: begin
				state_next.rdata = lcrb_half(cons[1], rel[0]);
				state_next.err = reg_wr;
			end
			lcrb_pkg::A_CYCLES, lcrb_pkg::A_CYCLES + lcrb_pkg::A_LOW_WORD: begin
				state_next.rdata = lcrb_half(state_reg.cycles, rel[0]);
				if (reg_wr) begin
					state_next.cycles = lcrb_put(state_next.cycles, rel[0], reg_wdata); // [RULE4]
				end
			end
			lcrb_pkg::A_TRIPS, lcrb_pkg::A_TRIPS + lcrb_pkg::A_LOW_WORD: begin
				state_next.rdata = lcrb_half(state_reg.trips, rel[0]);
				if (reg_wr) begin
					state_next.trips = lcrb_put(state_next.trips, rel[0], reg_wdata); // [RULE4]
				end
			end
			lcrb_pkg::A_HOURS, lcrb_pkg::A_HOURS + lcrb_pkg::A_LOW_WORD: begin
				state_next.rdata = lcrb_half(state_reg.hours, rel[0]);
				if (reg_wr) begin
					state_next.hours = lcrb_put(state_next.hours, rel[0], reg_wdata); // [RULE5]
				end
			end
			lcrb_pkg::A_WEIGHT1: begin
				state_next.rdata = state_reg.weight[0];
				if (reg_wr) begin
					state_next.weight[0] = reg_wdata; // [RULE10]
				end
			end
			lcrb_pkg::A_WEIGHT2: begin
				state_next.rdata = state_reg.weight[1];
				if (reg_wr) begin
					state_next.weight[1] = reg_wdata; // [RULE10]
				end
			end
			default: begin
				state_next.err = reg_rd | reg_wr;
			end
		endcase
		if (!(reg_rd | reg_wr)) begin
			state_next.rdata = 16'h0000;
			state_next.err = 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '0;
			state_reg.weight <= {lcrb_pkg::WEIGHT_RST, lcrb_pkg::WEIGHT_RST}; // [RULE10]
			state_reg.cycles <= lcrb_pkg::COUNT_RST;
			state_reg.trips <= lcrb_pkg::COUNT_RST;
			state_reg.hours <= lcrb_pkg::COUNT_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign reg_rdata = state_reg.rdata;
	assign reg_ack = state_reg.ack;
	assign reg_err = state_reg.err;
	assign coil_drive_input = state_reg.coil;
endmodule

//--- lcrb_channel_tb_top.sv
// Testbench of the load channel register bank
`timescale 1ns/1ns
module lcrb_channel_tb_top;
	localparam int CH = 2;
	localparam logic [15:0] OFF = 16'(lcrb_pkg::CH_SPAN * (CH - 1));
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [1:0] kind = 2'h0;
	logic [1:0] lvl = 2'h0;
	logic [15:0] addr = 16'h0000;
	logic rd = 1'h0;
	logic wr = 1'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [15:0] got;
	logic ack;
	logic err;
	logic coil;
	logic in1;
	logic in2;
	int fails = 0;
	int n_checks = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	// Short hour keeps the running-time and flow figures reachable
	lcrb_channel #(.CH_INDEX(CH), .CYC_PER_HOUR(40'h64)) lcrb_channel_i (
		.clk(clk), .rst_b(rst_b), .product_kind(kind), .first_pulse_input(in1),
		.second_pulse_input(in2), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack), .reg_err(err),
		.coil_drive_input(coil));
	lcrb_field_model lcrb_field_model_i (.clk(clk), .kind(kind), .coil(coil),
		.pin_lvl(lvl), .in1(in1), .in2(in2));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("Checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] v);
		n_checks++;
		if (v !== e) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", s, e, v);
		end
	endtask
	task automatic xf(input logic w, input string s, input logic [15:0] a, d, input logic e);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		addr <= a + OFF;
		wdata <= d;
		@(posedge clk);
		rd <= 1'h0;
		wr <= 1'h0;
		#1;
		got = rdata;
		chk({s, " ack err"}, {14'h0000, 1'h1, e}, {14'h0000, ack, err});
		if (!w) begin
			chk(s, d, rdata);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic pins(input logic [1:0] v);
		@(posedge clk);
		lvl <= v;
		tick(8);
	endtask
	task automatic pulse(input int m);
		@(posedge clk);
		lvl[m] <= 1'h1;
		tick(10);
		lvl[m] <= 1'h0;
		tick(39);
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			test_done();
		end
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		tick(8);
		rst_b <= 1'h1;
		xf(1'h0, "weight1", lcrb_pkg::A_WEIGHT1, lcrb_pkg::WEIGHT_RST, 1'h0);
		xf(1'h0, "weight2", lcrb_pkg::A_WEIGHT2, lcrb_pkg::WEIGHT_RST, 1'h0);
		xf(1'h0, "ch1 place", lcrb_pkg::A_STATUS - OFF, 16'h0000, 1'h1);
		xf(1'h0, "gap", lcrb_pkg::A_ORDER + 16'h0001, 16'h0000, 1'h1);
		$display("reset test done");
		@(posedge clk) kind <= lcrb_pkg::KIND_BREAKER;
		pins(2'h3);
		xf(1'h0, "closed", lcrb_pkg::A_STATUS, 16'h0003, 1'h0);
		pins(2'h1);
		xf(1'h0, "tripped", lcrb_pkg::A_STATUS, 16'h0001, 1'h0);
		xf(1'h0, "cycles hi", lcrb_pkg::A_CYCLES, 16'h0000, 1'h0);
		xf(1'h0, "cycles lo", lcrb_pkg::A_CYCLES + 16'h0001, 16'h0001, 1'h0);
		xf(1'h0, "trips lo", lcrb_pkg::A_TRIPS + 16'h0001, 16'h0001, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_TRIPS, 16'hBEEF, 1'h0);
		xf(1'h0, "trips hi", lcrb_pkg::A_TRIPS, 16'hBEEF, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_STATUS, 16'h0003, 1'h1);
		xf(1'h1, "w", lcrb_pkg::A_HOURS + 16'h0001, 16'h0000, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_HOURS, 16'h00A5, 1'h0);
		tick(150);
		xf(1'h0, "hours hi", lcrb_pkg::A_HOURS, 16'h00A5, 1'h0);
		xf(1'h0, "r", lcrb_pkg::A_HOURS + 16'h0001, 16'h0001, 1'h0);
		chk("hours lo", 16'h0001, got);
		xf(1'h1, "w", lcrb_pkg::A_CYCLES + 16'h0001, 16'h1234, 1'h0);
		xf(1'h0, "cycles set", lcrb_pkg::A_CYCLES + 16'h0001, 16'h1234, 1'h0);
		$display("breaker test done");
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0002, 1'h0);
		tick(2);
		chk("coil on", 16'h0001, 16'(coil));
		xf(1'h0, "cleared", lcrb_pkg::A_ORDER, 16'h0000, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0003, 1'h0);
		tick(2);
		chk("coil kept", 16'h0001, 16'(coil));
		xf(1'h0, "both held", lcrb_pkg::A_ORDER, 16'h0003, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0001, 1'h0);
		tick(2);
		chk("coil off", 16'h0000, 16'(coil));
		@(posedge clk) kind <= lcrb_pkg::KIND_NONE;
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0002, 1'h0);
		tick(2);
		xf(1'h0, "no product", lcrb_pkg::A_ORDER, 16'h0002, 1'h0);
		chk("coil idle", 16'h0000, 16'(coil));
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0000, 1'h0);
		$display("order test done");
		@(posedge clk) kind <= lcrb_pkg::KIND_CONTACTOR;
		pins(2'h2);
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0002, 1'h0);
		tick(10);
		xf(1'h0, "contactor", lcrb_pkg::A_STATUS, 16'h0003, 1'h0);
		pins(2'h0);
		xf(1'h0, "absent", lcrb_pkg::A_STATUS, 16'h0001, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0001, 1'h0);
		tick(2);
		xf(1'h0, "absent order", lcrb_pkg::A_ORDER, 16'h0001, 1'h0);
		$display("contactor test done");
		@(posedge clk) kind <= lcrb_pkg::KIND_METER;
		xf(1'h1, "w", lcrb_pkg::A_ORDER, 16'h0000, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_WEIGHT1, 16'h0003, 1'h0);
		xf(1'h0, "weight set", lcrb_pkg::A_WEIGHT1, 16'h0003, 1'h0);
		pulse(0);
		pins(2'h3);
		xf(1'h0, "pulses", lcrb_pkg::A_STATUS, 16'h0003, 1'h0);
		pins(2'h0);
		tick(100);
		xf(1'h0, "flow1 hi", lcrb_pkg::A_FLOW1, 16'h40C0, 1'h0);
		xf(1'h0, "flow1 lo", lcrb_pkg::A_FLOW1 + 16'h0001, 16'h0000, 1'h0);
		xf(1'h0, "flow2", lcrb_pkg::A_FLOW2, 16'h0000, 1'h0);
		xf(1'h0, "cons1", lcrb_pkg::A_CONS1 + 16'h0001, 16'h0006, 1'h0);
		xf(1'h0, "cons2", lcrb_pkg::A_CONS2 + 16'h0001, 16'h000A, 1'h0);
		xf(1'h1, "w", lcrb_pkg::A_FLOW1, 16'h0001, 1'h1);
		xf(1'h1, "w", lcrb_pkg::A_CONS1, 16'h0001, 1'h1);
		// Second meter on its own weight; the last period of 50 cycles sets the flow
		xf(1'h1, "w", lcrb_pkg::A_WEIGHT2, 16'h0005, 1'h0);
		xf(1'h0, "weight2 set", lcrb_pkg::A_WEIGHT2, 16'h0005, 1'h0);
		pulse(1);
		pulse(1);
		tick(100);
		xf(1'h0, "flow2 hi", lcrb_pkg::A_FLOW2, 16'h4120, 1'h0);
		xf(1'h0, "flow2 lo", lcrb_pkg::A_FLOW2 + 16'h0001, 16'h0000, 1'h0);
		xf(1'h0, "cons2 new", lcrb_pkg::A_CONS2 + 16'h0001, 16'h000F, 1'h0);
		xf(1'h0, "flow1 kept", lcrb_pkg::A_FLOW1, 16'h40C0, 1'h0);
		$display("meter test done");
		test_done();
	end
endmodule

//--- lcrb_checker_assertions.sv
// Port assertions of the load channel register bank
`timescale 1ns/1ns
module lcrb_checker #(
	parameter int CH_INDEX = 1
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [1:0] product_kind,
	input wire logic first_pulse_input,
	input wire logic second_pulse_input,
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_ack,
	input wire logic reg_err,
	input wire logic coil_drive_input
);
	localparam logic [15:0] OFF = 16'(lcrb_pkg::CH_SPAN * (CH_INDEX - 1));
	wire logic [15:0] a = reg_addr - OFF;
	wire logic req = reg_rd | reg_wr;
	wire logic ord = reg_wr && a == lcrb_pkg::A_ORDER;
	wire logic wt1 = a == lcrb_pkg::A_WEIGHT1;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	ack_one_cycle_a: assert property (req |=> reg_ack)
		else $error("no ack after strobe");
	ack_quiet_a: assert property (!req |=> !reg_ack && !reg_err && reg_rdata == 16'h0000)
		else $error("answer without strobe");
	status_ro_a: assert property (reg_wr && a == lcrb_pkg::A_STATUS |=> reg_err)
		else $error("status write accepted");
	flow_ro_a: assert property (reg_wr && a == lcrb_pkg::A_FLOW1 |=> reg_err)
		else $error("flow write accepted");
	map_gap_a: assert property (reg_rd && !reg_wr && a == lcrb_pkg::A_ORDER + 16'h0001
		|=> reg_err && reg_rdata == 16'h0000) else $error("gap address answered");
	weight_rw_a: assert property (reg_wr && wt1 ##1 !reg_wr ##1 reg_rd && !reg_wr && wt1
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("weight not kept");
	close_order_a: assert property (ord && reg_wdata[1:0] == 2'h2 && product_kind == 2'h1
		##1 !reg_wr |=> coil_drive_input) else $error("coil not closed");
	both_bits_a: assert property (ord && reg_wdata[1:0] == 2'h3 ##1 !reg_wr
		|=> $stable(coil_drive_input)) else $error("coil moved on double order");
	cover property (reg_ack && reg_err);
	cover property ($rose(coil_drive_input));
	cover property (reg_ack && !reg_err && reg_rdata != 16'h0000);
endmodule

bind lcrb_channel lcrb_checker #(.CH_INDEX(CH_INDEX)) lcrb_checker_i (
	.clk(clk), .rst_b(rst_b), .product_kind(product_kind),
	.first_pulse_input(first_pulse_input), .second_pulse_input(second_pulse_input),
	.reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_err(reg_err),
	.coil_drive_input(coil_drive_input)
);

//--- lcrb_field_model.sv
// Field product model driving the two channel pins
`timescale 1ns/1ns
module lcrb_field_model (
	input wire logic clk,
	input wire logic [1:0] kind,
	input wire logic coil,
	input wire logic [1:0] pin_lvl,
	output logic in1,
	output logic in2
);
	logic [1:0] coil_reg = 2'h0;
	// Contacts lag the coil, as a real armature does
	always_ff @(posedge clk) begin
		coil_reg <= {coil_reg[0], coil};
	end
	always_comb begin
		in1 = (kind == lcrb_pkg::KIND_CONTACTOR) ? coil_reg[1] : pin_lvl[0];
		in2 = pin_lvl[1];
	end
endmodule

//--- lcrb_pkg.sv
// Constants and types shared by the load channel register bank
package lcrb_pkg;
	// ----------------------------------------------------------------
	// Register addresses of channel 1
	// ----------------------------------------------------------------
	localparam logic [15:0] A_STATUS = 16'h3778;
	localparam logic [15:0] A_ORDER = 16'h3779;
	localparam logic [15:0] A_FLOW1 = 16'h377C;
	localparam logic [15:0] A_FLOW2 = 16'h377E;
	localparam logic [15:0] A_CONS1 = 16'h3780;
	localparam logic [15:0] A_CONS2 = 16'h3782;
	localparam logic [15:0] A_CYCLES = 16'h3784;
	localparam logic [15:0] A_TRIPS = 16'h3786;
	localparam logic [15:0] A_HOURS = 16'h3788;
	localparam logic [15:0] A_WEIGHT1 = 16'h3796;
	localparam logic [15:0] A_WEIGHT2 = 16'h3797;
	localparam logic [15:0] A_LOW_WORD = 16'h0001;
	localparam int CH_SPAN = 40;
	localparam int CH_MAX = 7;
	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int BIT_FIRST = 0;
	localparam int BIT_SECOND = 1;
	localparam logic [15:0] WEIGHT_RST = 16'h000A;
	localparam logic [31:0] COUNT_RST = 32'h0000_0000;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint CLK_HZ = 125_000_000;
	localparam longint HOUR_S = 3600;
	localparam logic [39:0] HOUR_CYC = 40'(HOUR_S * CLK_HZ);
	localparam int SYNC_LEN = 3;
	// ----------------------------------------------------------------
	// Flow arithmetic
	// ----------------------------------------------------------------
	localparam int TIME_W = 40;
	localparam int FRAC = 16;
	localparam int QUOT_W = 72;
	localparam logic [7:0] FLT_BIAS = 8'h7F;
	localparam logic [6:0] DIV_STEPS = 7'h48;
	// ----------------------------------------------------------------
	// Kind of product on the channel
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_NONE = 2'b00,
		KIND_BREAKER = 2'b01,
		KIND_METER = 2'b10,
		KIND_CONTACTOR = 2'b11
	} lcrb_kind_t;
endpackage
